// >>> design/sqmf_if.sv
// Purpose: link between a shader thread end and the data port end
// Assumes: single clock, synchronous handshakes
// Notes: req_valid held until req_ready; replies are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface sqmf_if
    import sqmf_pkg::*;
    (input wire logic mclk, input wire logic rst_n);
    logic req_valid;
    logic req_ready;
    sqmf_msg_t req_kind;
    logic req_header;
    logic [SQMF_LOD_W-1:0] req_detail_level;
    logic [SQMF_LOD_W-1:0] req_mip_level_count;
    logic [SQMF_LOD_W-1:0] req_minimum_detail_level;
    logic [SQMF_DIM_W-1:0] req_width;
    logic [SQMF_DIM_W-1:0] req_height;
    logic [SQMF_DIM_W-1:0] req_depth;
    logic [SQMF_FMT_W-1:0] req_format;
    logic [SQMF_TYP_W-1:0] req_type;
    logic [SQMF_BASE_IN_W-1:0] req_base;
    logic [7:0] req_exec_mask;
    logic [SQMF_FLUSH_W-1:0] req_flush;
    logic req_slm;
    logic acc_done;
    logic rsp_valid;
    logic rsp_fence;
    logic [SQMF_DIM_W-1:0] rsp_width;
    logic [SQMF_DIM_W-1:0] rsp_height;
    logic [SQMF_DIM_W-1:0] rsp_depth;
    logic [SQMF_FMT_W-1:0] rsp_format;
    logic [SQMF_TYP_W-1:0] rsp_type;
    logic [SQMF_BASE_OUT_W-1:0] rsp_base;
    logic wb_read;
    logic wb_release;
    logic [SQMF_FLUSH_W-1:0] flush_busy;
    modport port_end (
        input mclk, rst_n, req_valid, req_kind, req_header, req_detail_level,
        req_mip_level_count, req_minimum_detail_level, req_width, req_height,
        req_depth, req_format, req_type, req_base, req_exec_mask, req_flush,
        req_slm, acc_done, wb_read,
        output req_ready, rsp_valid, rsp_fence, rsp_width, rsp_height,
        rsp_depth, rsp_format, rsp_type, rsp_base, wb_release, flush_busy
    );
    modport thread_end (
        input mclk, rst_n, req_ready, rsp_valid, rsp_fence, rsp_width,
        rsp_height, rsp_depth, rsp_format, rsp_type, rsp_base, wb_release,
        flush_busy,
        output req_valid, req_kind, req_header, req_detail_level,
        req_mip_level_count, req_minimum_detail_level, req_width, req_height,
        req_depth, req_format, req_type, req_base, req_exec_mask, req_flush,
        req_slm, acc_done, wb_read
    );
endinterface
`default_nettype wire

// >>> design/sqmf_pkg.sv
// Purpose: shared constants and types for surface query and memory fence
// Assumes: one thread slot per requester end, single clock
// Notes: widths of reply fields chosen plainly
package sqmf_pkg;
    localparam int unsigned SQMF_LOD_W = 4;
    localparam int unsigned SQMF_DIM_W = 14;
    localparam int unsigned SQMF_FMT_W = 9;
    localparam int unsigned SQMF_TYP_W = 3;
    localparam int unsigned SQMF_BASE_IN_W = 48;
    localparam int unsigned SQMF_BASE_OUT_W = 64;
    localparam int unsigned SQMF_CNT_W = 6;
    localparam int unsigned SQMF_FLUSH_W = 4;
    localparam logic [4:0] SQMF_LOD_LIMIT = 5'h0f;
    localparam int unsigned SQMF_FLUSH_LAT = 3;
    // flush control bit positions inside fence_descriptor flush field
    localparam int unsigned SQMF_FL_RW = 0;
    localparam int unsigned SQMF_FL_CONST = 1;
    localparam int unsigned SQMF_FL_TEX = 2;
    localparam int unsigned SQMF_FL_INST = 3;
    // partition map: rw, constant and texture share partition 0
    localparam logic [SQMF_FLUSH_W-1:0] SQMF_PART0 = 4'h7;
    localparam logic [SQMF_FLUSH_W-1:0] SQMF_PART1 = 4'h8;
    // message kinds on the request channel
    typedef enum logic [1:0] {
        SQMF_MSG_ACCESS = 2'b00,
        SQMF_MSG_QUERY = 2'b01,
        SQMF_MSG_FENCE = 2'b10
    } sqmf_msg_t;
endpackage

// >>> design/sqmf_port.sv
// Purpose: data port end handling surface query and memory fence
// Assumes: one thread; acc_done pulses once per completed access
// Notes: surface state arrives with the query request
// Behaviour
// - detail level valid below mip count, sum below 15
// - invalid level returns zero dimensions
// - query returns format, type and dimensions
// - query ignores mask, no coordinate bounds checking
// - thread sends query without header
// - 48-bit base widened to 64 bits
// - fence blocks later messages until earlier complete
// - fence ignores mask and bounds, both models
// - fence completion writes undefined writeback value
// - writeback read stalls until prior observable
// - thread reads writeback before next message
// - thread fences before group barrier
// - shared memory observable to whole group
// - coherent cache observable to system too
// - noncoherent cache observable to graphics only
// - fence carries optional cache flush controls
// - flush of one type flushes partition
// - fence completion does not imply flush done
// - thread confirms flush with global read
`timescale 1ns/100ps
`default_nettype none
module sqmf_port
    import sqmf_pkg::*;
#(
    parameter int unsigned MAX_OUT = 32
) (
    sqmf_if.port_end lnk, // link to thread end
    output logic [SQMF_CNT_W-1:0] outstanding, // accesses in flight
    output logic fence_pending // fence awaiting completion
);
    // refuse a limit that the in-flight counter cannot hold
    if (MAX_OUT < 1 || MAX_OUT >= (1 << SQMF_CNT_W)) begin : g_bad_max_out
        $error("sqmf_port: MAX_OUT out of range");
    end

    // whole state of the port end in one word; replies and the release
    // strobe are registered so the thread never sees a combinational path
    // from its own request back to itself
    typedef struct packed {
        logic req_ready;
        logic rsp_valid;
        logic rsp_fence;
        logic [SQMF_DIM_W-1:0] rsp_width;
        logic [SQMF_DIM_W-1:0] rsp_height;
        logic [SQMF_DIM_W-1:0] rsp_depth;
        logic [SQMF_FMT_W-1:0] rsp_format;
        logic [SQMF_TYP_W-1:0] rsp_type;
        logic [SQMF_BASE_OUT_W-1:0] rsp_base;
        logic wb_release;
        logic [SQMF_FLUSH_W-1:0] flush_busy;
        logic [1:0] flush_cnt;
        logic [SQMF_CNT_W-1:0] outstanding;
        logic fence_pending;
        logic fence_done;
        logic wb_wait;
    } sqmf_port_t;

    sqmf_port_t s_r;
    sqmf_port_t s_nxt;

    logic take;
    logic lod_ok;
    logic [4:0] lod_sum;
    logic [SQMF_FLUSH_W-1:0] flush_req;
    logic take_acc;
    logic acc_ret;
    logic [SQMF_DIM_W-1:0] w_mip;
    logic [SQMF_DIM_W-1:0] h_mip;
    logic [SQMF_DIM_W-1:0] d_mip;

    // a message is taken on the edge where valid meets ready
    assign take = lnk.req_valid && s_r.req_ready;
    // an access taken this cycle
    assign take_acc = take && (lnk.req_kind == SQMF_MSG_ACCESS);
    // a stray completion with nothing in flight is dropped, never wraps
    assign acc_ret = lnk.acc_done && (s_r.outstanding != '0);
    assign lod_sum = {1'b0, lnk.req_minimum_detail_level} + {1'b0, lnk.req_detail_level};
    // sum is five bits wide so two large levels cannot wrap below the limit
    // level check uses only the levels; exec mask and coordinates never looked at
    assign lod_ok = (lnk.req_detail_level < lnk.req_mip_level_count)
        && (lod_sum < SQMF_LOD_LIMIT);

    // dimensions of the selected level: minimum plus requested level,
    // each step halving the base size, never below one
    always_comb begin
        w_mip = lnk.req_width >> lod_sum;
        h_mip = lnk.req_height >> lod_sum;
        d_mip = lnk.req_depth >> lod_sum;
        if (w_mip == '0)
            w_mip = SQMF_DIM_W'(1);
        if (h_mip == '0)
            h_mip = SQMF_DIM_W'(1);
        if (d_mip == '0)
            d_mip = SQMF_DIM_W'(1);
    end

    // widen requested flush to whole partitions
    // a partition is the unit the cache flushes, so one bit widens to all
    always_comb begin
        flush_req = '0;
        if ((lnk.req_flush & SQMF_PART0) != '0)
            flush_req = flush_req | SQMF_PART0;
        if ((lnk.req_flush & SQMF_PART1) != '0)
            flush_req = flush_req | SQMF_PART1;
    end

    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.wb_release = 1'b0;
        // per-thread in-flight count; a take and a return in one cycle cancel,
        // queries and fences never enter the count
        if (take_acc && !acc_ret)
            s_nxt.outstanding = s_r.outstanding + 1'b1;
        else if (!take_acc && acc_ret)
            s_nxt.outstanding = s_r.outstanding - 1'b1;
        // cache flush drains in background; a flush taken below restarts it,
        // so a new request wins over the end of an old one
        if (s_r.flush_cnt != 2'h0) begin
            s_nxt.flush_cnt = s_r.flush_cnt - 2'h1;
            if (s_r.flush_cnt == 2'h1)
                s_nxt.flush_busy = '0;
        end
        if (take) begin
            case (lnk.req_kind)
                SQMF_MSG_QUERY: begin
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.rsp_fence = 1'b0;
                    s_nxt.rsp_format = lnk.req_format;
                    s_nxt.rsp_type = lnk.req_type;
                    s_nxt.rsp_width = lod_ok ? w_mip : '0;
                    s_nxt.rsp_height = lod_ok ? h_mip : '0;
                    s_nxt.rsp_depth = lod_ok ? d_mip : '0;
                    s_nxt.rsp_base = {16'h0000, lnk.req_base};
                end
                SQMF_MSG_FENCE: begin
                    // close the request side at once: the thread may not
                    // slip a message in before the fence is seen
                    // same path for bound surface and shared memory
                    s_nxt.fence_pending = 1'b1;
                    s_nxt.req_ready = 1'b0;
                    s_nxt.flush_busy = s_nxt.flush_busy | flush_req;
                    if (flush_req != '0)
                        s_nxt.flush_cnt = 2'(SQMF_FLUSH_LAT);
                end
                default: begin
                    if (s_r.outstanding + 1'b1 >= SQMF_CNT_W'(MAX_OUT))
                        s_nxt.req_ready = 1'b0;
                end
            endcase
        end
        // reopen after in-flight count drops, when no fence holds
        if (!s_r.req_ready && !s_r.fence_pending && !s_r.fence_done
                && !s_r.wb_wait && s_r.outstanding < SQMF_CNT_W'(MAX_OUT))
            s_nxt.req_ready = 1'b1;
        // fence completes once earlier accesses drained, flush not awaited
        if (s_r.fence_pending && s_r.outstanding == '0) begin
            s_nxt.fence_pending = 1'b0;
            s_nxt.fence_done = 1'b1;
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp_fence = 1'b1;
        end
        // writeback read stalls while anything still in flight
        // the release also reopens the request side closed by the fence
        if (s_r.fence_done && lnk.wb_read) begin
            s_nxt.fence_done = 1'b0;
            s_nxt.wb_wait = 1'b1;
        end
        if (s_r.wb_wait && s_r.outstanding == '0) begin
            s_nxt.wb_wait = 1'b0;
            s_nxt.wb_release = 1'b1;
            s_nxt.req_ready = 1'b1;
        end
    end

    // state register
    // reset leaves the request side open so a first message can be taken
    always_ff @(posedge lnk.mclk or negedge lnk.rst_n) begin
        if (!lnk.rst_n) begin
            s_r <= '0;
            s_r.req_ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // every link and side output comes straight from the state register
    assign lnk.req_ready = s_r.req_ready;
    assign lnk.rsp_valid = s_r.rsp_valid;
    assign lnk.rsp_fence = s_r.rsp_fence;
    assign lnk.rsp_width = s_r.rsp_width;
    assign lnk.rsp_height = s_r.rsp_height;
    assign lnk.rsp_depth = s_r.rsp_depth;
    assign lnk.rsp_format = s_r.rsp_format;
    assign lnk.rsp_type = s_r.rsp_type;
    assign lnk.rsp_base = s_r.rsp_base;
    assign lnk.wb_release = s_r.wb_release;
    assign lnk.flush_busy = s_r.flush_busy;
    assign outstanding = s_r.outstanding;
    assign fence_pending = s_r.fence_pending;
endmodule
`default_nettype wire

// >>> design/sqmf_thread.sv
// Purpose: shader thread end issuing queries, accesses and fences
// Assumes: user holds a command until cmd_ready accepted it
// Notes: blocks new commands between fence and writeback release
`timescale 1ns/100ps
`default_nettype none
module sqmf_thread
    import sqmf_pkg::*;
(
    sqmf_if.thread_end lnk, // link to data port end
    input wire logic cmd_valid, // user command present
    input wire sqmf_msg_t cmd_kind, // command kind
    input wire logic [SQMF_LOD_W-1:0] cmd_detail_level, // query level
    input wire logic [SQMF_LOD_W-1:0] cmd_mip_level_count, // surface mips
    input wire logic [SQMF_LOD_W-1:0] cmd_minimum_detail_level, // surface min
    input wire logic [SQMF_DIM_W-1:0] cmd_width, // base width
    input wire logic [SQMF_DIM_W-1:0] cmd_height, // base height
    input wire logic [SQMF_DIM_W-1:0] cmd_depth, // base depth
    input wire logic [SQMF_FMT_W-1:0] cmd_format, // surface format
    input wire logic [SQMF_TYP_W-1:0] cmd_type, // surface type
    input wire logic [SQMF_BASE_IN_W-1:0] cmd_base, // 48-bit base
    input wire logic [SQMF_FLUSH_W-1:0] cmd_flush, // fence flush bits
    input wire logic cmd_slm, // fence on shared memory
    input wire logic acc_done_in, // an access completed
    output logic cmd_ready, // command accepted in the previous cycle
    output logic fenced, // fence sequence in progress
    output logic rsp_valid_out, // reply pulse
    output logic [SQMF_BASE_OUT_W-1:0] rsp_base_out // widened base
);
    typedef struct packed {
        logic busy;
        logic fenced;
        logic wb_pend;
        logic cmd_ready;
        logic rsp_valid;
        logic [SQMF_BASE_OUT_W-1:0] rsp_base;
    } sqmf_thr_t;

    sqmf_thr_t s_r;
    sqmf_thr_t s_nxt;

    // drive request straight from user command
    assign lnk.req_valid = cmd_valid && !s_r.fenced && !s_r.cmd_ready;
    assign lnk.req_kind = cmd_kind;
    assign lnk.req_header = 1'b0;
    assign lnk.req_detail_level = cmd_detail_level;
    assign lnk.req_mip_level_count = cmd_mip_level_count;
    assign lnk.req_minimum_detail_level = cmd_minimum_detail_level;
    assign lnk.req_width = cmd_width;
    assign lnk.req_height = cmd_height;
    assign lnk.req_depth = cmd_depth;
    assign lnk.req_format = cmd_format;
    assign lnk.req_type = cmd_type;
    assign lnk.req_base = cmd_base;
    assign lnk.req_exec_mask = 8'hff;
    assign lnk.req_flush = cmd_flush;
    assign lnk.req_slm = cmd_slm;
    assign lnk.acc_done = acc_done_in;
    // read writeback once the fence reply has arrived
    assign lnk.wb_read = s_r.wb_pend;

    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd_ready = 1'b0;
        s_nxt.rsp_valid = lnk.rsp_valid && !lnk.rsp_fence;
        if (lnk.rsp_valid && !lnk.rsp_fence)
            s_nxt.rsp_base = lnk.rsp_base;
        if (lnk.req_valid && lnk.req_ready) begin
            s_nxt.cmd_ready = 1'b1;
            if (cmd_kind == SQMF_MSG_FENCE)
                s_nxt.fenced = 1'b1;
        end
        if (lnk.rsp_valid && lnk.rsp_fence)
            s_nxt.wb_pend = 1'b1;
        if (s_r.wb_pend)
            s_nxt.wb_pend = 1'b0;
        if (lnk.wb_release)
            s_nxt.fenced = 1'b0;
        s_nxt.busy = s_nxt.fenced;
    end

    // state register
    always_ff @(posedge lnk.mclk or negedge lnk.rst_n) begin
        if (!lnk.rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign cmd_ready = s_r.cmd_ready;
    assign fenced = s_r.busy;
    assign rsp_valid_out = s_r.rsp_valid;
    assign rsp_base_out = s_r.rsp_base;
endmodule
`default_nettype wire

// >>> verification/sqmf_chk.sv
// Purpose: link assertions for query and fence traffic
// Assumes: one clock, rst_n async low
// Notes: counts accesses in flight itself
`timescale 1ns/100ps
`default_nettype none
module sqmf_chk
    import sqmf_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst_n, // reset
    input wire logic req_valid, // request
    input wire logic req_ready, // accept
    input wire sqmf_msg_t req_kind, // kind
    input wire logic req_header, // header present
    input wire logic [SQMF_LOD_W-1:0] req_detail_level, // level
    input wire logic [SQMF_LOD_W-1:0] req_mip_level_count, // mips
    input wire logic [SQMF_LOD_W-1:0] req_minimum_detail_level, // min
    input wire logic [SQMF_FMT_W-1:0] req_format, // format
    input wire logic [SQMF_BASE_IN_W-1:0] req_base, // base
    input wire logic [SQMF_FLUSH_W-1:0] req_flush, // flush
    input wire logic acc_done, // access done
    input wire logic rsp_valid, // reply
    input wire logic rsp_fence, // fence reply
    input wire logic [SQMF_DIM_W-1:0] rsp_width, // width
    input wire logic [SQMF_FMT_W-1:0] rsp_format, // format
    input wire logic [SQMF_BASE_OUT_W-1:0] rsp_base, // base
    input wire logic wb_read, // writeback read
    input wire logic wb_release, // stall end
    input wire logic [SQMF_FLUSH_W-1:0] flush_busy // flushing
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // take strobes and level check
    wire logic qt = req_valid && req_ready && req_kind == SQMF_MSG_QUERY;
    wire logic ft = req_valid && req_ready && req_kind == SQMF_MSG_FENCE;
    wire logic at = req_valid && req_ready && req_kind == SQMF_MSG_ACCESS;
    wire logic ok = req_detail_level < req_mip_level_count
        && {1'b0, req_minimum_detail_level} + {1'b0, req_detail_level} < SQMF_LOD_LIMIT;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    // accesses in flight
    always_comb cnt_nxt = cnt_r + {6'h00, at} - {6'h00, acc_done && cnt_r != 7'h00};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cnt_r <= 7'h00;
        else cnt_r <= cnt_nxt;
    end
    qry_reply_a: assert property (qt |=> rsp_valid && !rsp_fence)
        else $error("query reply missing");
    no_header_a: assert property (qt |-> !req_header)
        else $error("query sent with header");
    lod_zero_a: assert property (qt && !ok |=> rsp_width == 14'h0000)
        else $error("invalid level width not zero");
    fmt_pass_a: assert property (qt |=> rsp_format == $past(req_format))
        else $error("format not returned");
    base_wide_a: assert property (qt |=> rsp_base == {16'h0000, $past(req_base)})
        else $error("base not widened");
    fence_hold_a: assert property (ft |=> (!req_ready) [*4])
        else $error("request taken during fence");
    fence_drain_a: assert property (rsp_valid && rsp_fence |-> cnt_r == 7'h00)
        else $error("fence done with accesses in flight");
    fence_quick_a: assert property (ft && cnt_r == 7'h00 |-> ##2 rsp_valid && rsp_fence)
        else $error("idle fence reply late");
    wb_stall_a: assert property (wb_read && cnt_r == 7'h00 |-> ##2 wb_release)
        else $error("writeback release late");
    release_ok_a: assert property (wb_release |-> req_ready && cnt_r == 7'h00)
        else $error("release while not drained");
    flush_part_a: assert property ((ft && (req_flush & SQMF_PART0) != 4'h0) |->
        ##[1:3] (flush_busy & SQMF_PART0) == SQMF_PART0) else $error("partition not flushed");
endmodule
`default_nettype wire

// >>> verification/sqmf_tb.sv
// Purpose: bench for thread and port ends joined by the link
// Assumes: 10 MHz mclk, xorshift stimulus seeded with 38308
// Notes: dims exact only when the minimum level is zero
`timescale 1ns/100ps
`default_nettype none
module sqmf_tb
    import sqmf_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic acc_done_in = 1'b0;
    logic cmd_slm = 1'b0;
    logic cmd_ready, fenced, rsp_valid_out;
    logic [5:0] outst;
    logic fpend;
    sqmf_msg_t cmd_kind = SQMF_MSG_ACCESS;
    logic [3:0] detail_level = 4'h0, mip = 4'h0, mn = 4'h0, cmd_flush = 4'h0;
    logic [13:0] w = 14'h0000, h = 14'h0000, d = 14'h0000;
    logic [8:0] fmt = 9'h000;
    logic [2:0] typ = 3'h0;
    logic [47:0] base = 48'h0;
    logic [63:0] rsp_base_out, lastb;
    logic [31:0] rs = 32'h000095a4;
    logic [55:0] e;
    logic [53:0] r;
    logic [55:0] eq[$];
    logic [63:0] eb[$];
    logic [11:0] tab[8] = '{12'h000, 12'h340, 12'h440, 12'h01e, 12'h12e, 12'hef0, 12'h0ff,
        12'h5a3};
    int errors = 0, n_compared = 0, n_out = 0, n_fence = 0, i, k;
    // free running clock
    always #50 mclk = ~mclk;
    sqmf_if i_sqmf_if (.mclk(mclk), .rst_n(rst_n));
    sqmf_port #(.MAX_OUT(32)) i_sqmf_port (.lnk(i_sqmf_if), .outstanding(outst),
        .fence_pending(fpend));
    sqmf_thread i_sqmf_thread (.lnk(i_sqmf_if), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_detail_level(detail_level), .cmd_mip_level_count(mip), .cmd_minimum_detail_level(mn),
        .cmd_width(w), .cmd_height(h), .cmd_depth(d), .cmd_format(fmt), .cmd_type(typ),
        .cmd_base(base), .cmd_flush(cmd_flush), .cmd_slm(cmd_slm), .acc_done_in(acc_done_in),
        .cmd_ready(cmd_ready), .fenced(fenced), .rsp_valid_out(rsp_valid_out),
        .rsp_base_out(rsp_base_out));
    sqmf_chk i_sqmf_chk (.mclk(mclk), .rst_n(rst_n), .req_valid(i_sqmf_if.req_valid),
        .req_ready(i_sqmf_if.req_ready), .req_kind(i_sqmf_if.req_kind),
        .req_header(i_sqmf_if.req_header),
        .req_detail_level(i_sqmf_if.req_detail_level),
        .req_mip_level_count(i_sqmf_if.req_mip_level_count),
        .req_minimum_detail_level(i_sqmf_if.req_minimum_detail_level),
        .req_format(i_sqmf_if.req_format), .req_base(i_sqmf_if.req_base),
        .req_flush(i_sqmf_if.req_flush), .acc_done(i_sqmf_if.acc_done),
        .rsp_valid(i_sqmf_if.rsp_valid), .rsp_fence(i_sqmf_if.rsp_fence),
        .rsp_width(i_sqmf_if.rsp_width), .rsp_format(i_sqmf_if.rsp_format),
        .rsp_base(i_sqmf_if.rsp_base), .wb_read(i_sqmf_if.wb_read),
        .wb_release(i_sqmf_if.wb_release), .flush_busy(i_sqmf_if.flush_busy));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // dimension at a valid mip level, never below one; zero for an invalid level
    function automatic logic [13:0] md(input logic [13:0] v, input logic [3:0] l, input logic ok);
        logic [13:0] t;
        t = v >> l;
        return ok ? (t == 14'h0000 ? 14'h0001 : t) : 14'h0000;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // query fields from a level code plus random surface state
    task automatic prep(input logic [11:0] c);
        logic ok;
        rs = xs(rs);
        ok = c[11:8] < c[7:4] && {1'b0, c[3:0]} + {1'b0, c[11:8]} < SQMF_LOD_LIMIT;
        detail_level <= c[11:8];
        mip <= c[7:4];
        mn <= c[3:0];
        w <= rs[13:0];
        h <= rs[27:14];
        d <= rs[31:18];
        fmt <= rs[8:0];
        typ <= rs[2:0];
        base <= {rs[15:0], rs};
        eq.push_back({c[3:0] == 4'h0, ok, rs[8:0], rs[2:0], md(rs[13:0], c[11:8], ok),
            md(rs[27:14], c[11:8], ok), md(rs[31:18], c[11:8], ok)});
        eb.push_back({16'h0000, rs[15:0], rs});
    endtask
    task automatic send(input sqmf_msg_t kd);
        @(posedge mclk);
        cmd_kind <= kd;
        cmd_valid <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 60);
        cmd_valid <= 1'b0;
        if (k >= 60) chk(64'h0, 64'h1);
    endtask
    task automatic drain(input int c);
        repeat (c) begin
            repeat (2) @(posedge mclk);
            acc_done_in <= 1'b1;
            n_out--;
            @(posedge mclk);
            acc_done_in <= 1'b0;
        end
    endtask
    // replies checked against the model queues
    always @(posedge mclk) begin
        if (i_sqmf_if.rsp_valid === 1'b1 && i_sqmf_if.rsp_fence === 1'b1) begin
            n_fence++;
            chk(64'(n_out), 64'h0);
        end else if (i_sqmf_if.rsp_valid === 1'b1) begin
            e = eq.pop_front();
            r = {i_sqmf_if.rsp_format, i_sqmf_if.rsp_type, i_sqmf_if.rsp_width,
                i_sqmf_if.rsp_height, i_sqmf_if.rsp_depth};
            if (e[55]) chk({10'h000, r}, {10'h000, e[53:0]});
            else chk({r[53:42], r[41:0] == 42'h0}, {e[53:42], !e[54]});
            lastb = eb.pop_front();
            chk(i_sqmf_if.rsp_base, lastb);
        end
        if (rsp_valid_out === 1'b1) chk(rsp_base_out, lastb);
    end
    // watchdog against a hung handshake
    initial begin
        #400000;
        errors++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (i = 0; i < 32; i++) begin
            prep(i < 8 ? tab[i] : (rs[12] ? rs[11:0] : {rs[11:4], 4'h0}));
            send(SQMF_MSG_QUERY);
        end
        $display("test queries done");
        for (i = 0; i < 4; i++) begin
            cmd_flush <= 4'h1 << i;
            cmd_slm <= i[0];
            send(SQMF_MSG_FENCE);
            k = 0;
            while (i_sqmf_if.flush_busy === 4'h0 && k < 4) begin
                @(posedge mclk);
                k++;
            end
            chk(i_sqmf_if.flush_busy, i < 3 ? SQMF_PART0 : SQMF_PART1);
        end
        $display("test flush fences done");
        cmd_flush <= 4'h0;
        repeat (3) begin
            send(SQMF_MSG_ACCESS);
            n_out++;
        end
        send(SQMF_MSG_FENCE);
        prep(12'h340);
        @(posedge mclk);
        cmd_kind <= SQMF_MSG_QUERY;
        cmd_valid <= 1'b1;
        k = 0;
        repeat (8) begin
            @(posedge mclk);
            if (cmd_ready === 1'b1) k++;
        end
        chk(64'(k), 64'h0);
        chk({58'h0, outst}, 64'h3);
        chk({63'h0, fpend}, 64'h1);
        chk({63'h0, fenced}, 64'h1);
        drain(3);
        send(SQMF_MSG_QUERY);
        chk(64'(n_fence), 64'h5);
        repeat (10) @(posedge mclk);
        chk(64'(eq.size()), 64'h0);
        chk({58'h0, outst}, 64'h0);
        chk({63'h0, fpend}, 64'h0);
        chk({63'h0, fenced}, 64'h0);
        $display("test fence drain done");
        conclude();
    end
endmodule
`default_nettype wire
